//--- rtl/cwsp_link.sv
// cwsp_link: serial shifter on the programming clock
// assumes: visi is stable whenever visi_tog has toggled; word is read after word_tog crosses
`timescale 1ns/10ps
`default_nettype none
`include "cwsp_map.svh"
module cwsp_link
(
    // link
    input  wire logic                prog_clk,
    input  wire logic                resetn,
    input  wire logic                pgd_in,
    output var  logic                pgd_out,
    output var  logic                pgd_oe,
    // core side
    output var  cwsp_pkg::link_word_s word,
    output var  logic                word_tog,
    input  wire logic [15:0]         visi,
    input  wire logic                visi_tog
);
    logic [27:0] sr_q;
    logic [4:0]  cnt_q;
    logic        rd_q;
    logic [14:0] osr_q;
    logic [15:0] visi_l_q;
    logic        vt_s1_q;
    logic        vt_s2_q;
    logic        vt_s3_q;

    wire  [27:0] sr_d      = {pgd_in, sr_q[27:1]};
    wire         last      = cnt_q == `CWSP_FRAME_LAST;
    wire         cmd_done  = cnt_q == `CWSP_CMD_LAST_BIT;
    wire         is_rd     = {pgd_in, sr_q[27:25]} == `CWSP_CMD_SHIFT_OUT;
    wire         out_start = rd_q && (cnt_q == `CWSP_OUT_START);
    wire         visi_ev   = vt_s2_q ^ vt_s3_q;

    // frame receive, lsb first
    always_ff @(posedge prog_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sr_q     <= 28'h0000000;
            cnt_q    <= 5'h00;
            word     <= '0;
            word_tog <= 1'b0;
        end
        else
        begin
            sr_q  <= sr_d;
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
            if (last)
            begin
                word     <= cwsp_pkg::link_word_s'(sr_d);
                word_tog <= ~word_tog;
            end
        end
    end

    // visibility word brought over from the core
    always_ff @(posedge prog_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vt_s1_q  <= 1'b0;
            vt_s2_q  <= 1'b0;
            vt_s3_q  <= 1'b0;
            visi_l_q <= 16'h0000;
        end
        else
        begin
            vt_s1_q <= visi_tog;
            vt_s2_q <= vt_s1_q;
            vt_s3_q <= vt_s2_q;
            if (visi_ev)
                visi_l_q <= visi;
        end
    end

    // shift-out: 8 idle data clocks, then 16 bits lsb first
    always_ff @(posedge prog_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_q    <= 1'b0;
            osr_q   <= 15'h0000;
            pgd_out <= 1'b0;
            pgd_oe  <= 1'b0;
        end
        else
        begin
            if (cmd_done)
                rd_q <= is_rd;
            else if (last)
                rd_q <= 1'b0;
            if (out_start)
            begin
                pgd_oe  <= 1'b1;
                pgd_out <= visi_l_q[0];
                osr_q   <= visi_l_q[15:1];
            end
            else if (last)
            begin
                pgd_oe  <= 1'b0;
                pgd_out <= 1'b0;
            end
            else if (pgd_oe)
            begin
                pgd_out <= osr_q[0];
                osr_q   <= {1'b0, osr_q[14:1]};
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/cwsp_map.svh
// cwsp_map.svh: constants of the configuration word serial programming block
// assumes: included by bare name from rtl/, definitions only
`ifndef CWSP_MAP_SVH
`define CWSP_MAP_SVH

// serial frame
`define CWSP_CMD_BITS        4
`define CWSP_DATA_BITS       24
`define CWSP_FRAME_LAST      5'h1B
`define CWSP_CMD_LAST_BIT    5'h03
`define CWSP_OUT_START       5'h0B
`define CWSP_CMD_EXEC        4'h0
`define CWSP_CMD_SHIFT_OUT   4'h1

// instruction patterns
`define CWSP_OP_MOV_LIT      4'h2
`define CWSP_OP_WR_NVM       20'h883B0
`define CWSP_OP_WR_TABLE_PAGE_REGISTER    20'h88019
`define CWSP_OP_WR_VISI      20'h883C2
`define CWSP_OP_RD_NVM       20'h803B0
`define CWSP_OP_TABLE_WRITE_LOW       24'hBB1B86
`define CWSP_OP_BSET_WR      24'hA8E761

// nonvolatile control register fields
`define CWSP_NVM_WR_BIT      15
`define CWSP_NVM_WREN_BIT    14
`define CWSP_NVM_CFG_OP      16'h4003
`define CWSP_NVM_OP_MASK     16'h400F
`define CWSP_NVM_RESET       16'h0000
`define CWSP_TABLE_PAGE_REGISTER_CFG      8'h00

// erased values and addresses of the configuration words
`define CWSP_CW1_RESET       16'h7FFF
`define CWSP_CWX_RESET       16'hFFFF
`define CWSP_LAST_WORD_ADDR  16'hFFFE
`define CWSP_WORD_STEP       16'h0002

// timing
`define CWSP_CLK_PERIOD_NS   40
`define CWSP_WRITE_TIME_NS   2000
`define CWSP_WRITE_CYCLES    ((`CWSP_WRITE_TIME_NS + `CWSP_CLK_PERIOD_NS - 1) / `CWSP_CLK_PERIOD_NS)

`endif

//--- rtl/cwsp_pkg.sv
// cwsp_pkg: types of the configuration word serial programming block
// assumes: cwsp_map.svh sits beside it
`include "cwsp_map.svh"
package cwsp_pkg;

    typedef struct packed {
        logic [`CWSP_DATA_BITS-1:0] data;
        logic [`CWSP_CMD_BITS-1:0]  cmd;
    } link_word_s;

    // word[0] is config word 1
    typedef struct packed {
        logic [3:0][15:0] word;
    } cfg_s;

    typedef enum logic [1:0] {
        ST_RELOAD,
        ST_IDLE,
        ST_WRITE
    } core_state_e;

endpackage

//--- rtl/cwsp_top.sv
// cwsp_top: configuration word store, reload and serial programming core
// assumes: prog_clk runs only inside frames; por_n restores erased flash (chip erase)
`timescale 1ns/10ps
`default_nettype none
`include "cwsp_map.svh"
// What this block does
// - every reset walks the flash config words, copying them into live config registers
// - programming changes flash only; live registers change at the next reset
// - programming only clears bits; ones return only by chip erase
// - erased config word 1 reads 7FFFh, words 2 to 4 read FFFFh
// - hardware clears write-start bit 15 when done; programmer polls it
// - shift-out command drives visibility register out on the data pin
module cwsp_top
#(
    parameter int unsigned WRITE_CYCLES   = `CWSP_WRITE_CYCLES,
    parameter logic [15:0] LAST_WORD_ADDR = `CWSP_LAST_WORD_ADDR
)
(
    // core clock and resets
    input  wire logic          clock,
    input  wire logic          resetn,
    input  wire logic          por_n,
    // programming pins
    input  wire logic          prog_clk,
    input  wire logic          pgd_in,
    output var  logic          pgd_out,
    output var  logic          pgd_oe,
    // live configuration
    output var  cwsp_pkg::cfg_s cfg_q,
    output var  logic          cfg_valid_q,
    output var  logic          write_busy_q
);
    cwsp_pkg::link_word_s   word;
    logic                   word_tog;
    logic                   tog_s1_q;
    logic                   tog_s2_q;
    logic                   tog_s3_q;
    logic [15:0]            w_q [16];
    logic [15:0]            nvm_q;
    logic [7:0]             table_page_register_q;
    logic [15:0]            visi_q;
    logic                   visi_tog_q;
    logic [15:0]            latch_data_q;
    logic [15:0]            latch_addr_q;
    logic [15:0]            flash_q [4];
    logic [15:0]            wcnt_q;
    logic [1:0]             idx_q;
    cwsp_pkg::core_state_e  state_q;
    logic [3:0]             hit;

    cwsp_link u_link
    (
        .prog_clk (prog_clk),
        .resetn   (resetn),
        .pgd_in   (pgd_in),
        .pgd_out  (pgd_out),
        .pgd_oe   (pgd_oe),
        .word     (word),
        .word_tog (word_tog),
        .visi     (visi_q),
        .visi_tog (visi_tog_q)
    );

    // instruction decode of the executed data field
    wire [23:0] d          = word.data;
    wire        exec       = (tog_s2_q ^ tog_s3_q) && (word.cmd == `CWSP_CMD_EXEC);
    wire        do_mov_lit = exec && (d[23:20] == `CWSP_OP_MOV_LIT);
    wire        do_wr_nvm  = exec && (d[23:4] == `CWSP_OP_WR_NVM);
    wire        do_wr_pag  = exec && (d[23:4] == `CWSP_OP_WR_TABLE_PAGE_REGISTER);
    wire        do_wr_visi = exec && (d[23:4] == `CWSP_OP_WR_VISI);
    wire        do_rd_nvm  = exec && (d[23:4] == `CWSP_OP_RD_NVM);
    wire        do_table_write_low  = exec && (d == `CWSP_OP_TABLE_WRITE_LOW);
    wire        do_bset    = exec && (d == `CWSP_OP_BSET_WR);
    wire [15:0] src        = w_q[d[3:0]];
    wire        cfg_op     = (nvm_q & `CWSP_NVM_OP_MASK) == `CWSP_NVM_CFG_OP;
    wire        start_wr   = do_bset && (state_q == cwsp_pkg::ST_IDLE) && cfg_op;
    wire        wr_done    = (state_q == cwsp_pkg::ST_WRITE) && (wcnt_q == 16'(WRITE_CYCLES - 1));
    wire        page_ok    = table_page_register_q == `CWSP_TABLE_PAGE_REGISTER_CFG;
    wire        wr_bit     = nvm_q[`CWSP_NVM_WR_BIT];

    // config word slots sit two addresses apart below the last word
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_hit
            assign hit[gi] = latch_addr_q == (LAST_WORD_ADDR - 16'(gi) * `CWSP_WORD_STEP);
        end
    endgenerate

    // frame toggle crossing
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end
        else
        begin
            tog_s1_q <= word_tog;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // working registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 16; i++)
                w_q[i] <= 16'h0000;
        end
        else
        begin
            if (do_mov_lit)
                w_q[d[3:0]] <= d[19:4];
            else if (do_rd_nvm)
                w_q[d[3:0]] <= nvm_q;
            else if (do_table_write_low)
                w_q[7] <= w_q[7] + `CWSP_WORD_STEP;
        end
    end

    // control, page, latch and visibility registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            nvm_q        <= `CWSP_NVM_RESET;
            table_page_register_q     <= 8'h00;
            visi_q       <= 16'h0000;
            visi_tog_q   <= 1'b0;
            latch_data_q <= `CWSP_CWX_RESET;
            latch_addr_q <= 16'h0000;
        end
        else
        begin
            if (start_wr)
                nvm_q[`CWSP_NVM_WR_BIT] <= 1'b1;
            else if (wr_done)
                nvm_q[`CWSP_NVM_WR_BIT] <= 1'b0;
            else if (do_wr_nvm)
                nvm_q <= {wr_bit, src[14:0]};
            if (do_wr_pag)
                table_page_register_q <= src[7:0];
            if (do_wr_visi)
            begin
                visi_q     <= src;
                visi_tog_q <= ~visi_tog_q;
            end
            if (do_table_write_low && !wr_bit)
            begin
                latch_data_q <= w_q[6];
                latch_addr_q <= w_q[7];
            end
        end
    end

    // write timer and reload sequencer
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q      <= cwsp_pkg::ST_RELOAD;
            wcnt_q       <= 16'h0000;
            idx_q        <= 2'h0;
            cfg_valid_q  <= 1'b0;
            write_busy_q <= 1'b0;
            cfg_q.word[0] <= `CWSP_CW1_RESET;
            cfg_q.word[1] <= `CWSP_CWX_RESET;
            cfg_q.word[2] <= `CWSP_CWX_RESET;
            cfg_q.word[3] <= `CWSP_CWX_RESET;
        end
        else
        begin
            case (state_q)
                cwsp_pkg::ST_RELOAD:
                begin
                    cfg_q.word[idx_q] <= flash_q[idx_q];
                    idx_q <= idx_q + 2'h1;
                    if (idx_q == 2'h3)
                    begin
                        state_q     <= cwsp_pkg::ST_IDLE;
                        cfg_valid_q <= 1'b1;
                    end
                end
                cwsp_pkg::ST_IDLE:
                begin
                    wcnt_q <= 16'h0000;
                    if (start_wr)
                    begin
                        state_q      <= cwsp_pkg::ST_WRITE;
                        write_busy_q <= 1'b1;
                    end
                end
                cwsp_pkg::ST_WRITE:
                begin
                    wcnt_q <= wcnt_q + 16'h0001;
                    if (wr_done)
                    begin
                        state_q      <= cwsp_pkg::ST_IDLE;
                        write_busy_q <= 1'b0;
                    end
                end
                default:
                    state_q <= cwsp_pkg::ST_IDLE;
            endcase
        end
    end

    // flash cells: kept over device reset, erased by por_n
    always_ff @(posedge clock or negedge por_n)
    begin
        if (!por_n)
        begin
            flash_q[0] <= `CWSP_CW1_RESET;
            flash_q[1] <= `CWSP_CWX_RESET;
            flash_q[2] <= `CWSP_CWX_RESET;
            flash_q[3] <= `CWSP_CWX_RESET;
        end
        else if (wr_done && page_ok)
        begin
            for (int i = 0; i < 4; i++)
                if (hit[i])
                    flash_q[i] <= flash_q[i] & latch_data_q;
        end
    end
endmodule
`default_nettype wire

//--- test/config_word_serial_programming_test.sv
// config_word_serial_programming_test: self-checking bench for cwsp_top
// assumes: cwsp_prog_model plays the programmer; monitor bound in
`timescale 1ns/10ps
`default_nettype none
module config_word_serial_programming_test;
    logic           clock;
    logic           resetn;
    logic           por_n;
    logic           prog_clk;
    wire logic      pgd_in;
    logic           pgd_out;
    logic           pgd_oe;
    cwsp_pkg::cfg_s cfg_q;
    logic           cfg_valid_q;
    logic           write_busy_q;
    localparam int unsigned WR_CYC = 4;
    int             busy_cycles;
    int             busy_base;
    logic [15:0]    rd;
    int             fail_count;
    int             samples_checked;
    int             cyc;

    cwsp_top #(.WRITE_CYCLES(WR_CYC)) dut_u
    (
        .clock(clock), .resetn(resetn), .por_n(por_n), .prog_clk(prog_clk), .pgd_in(pgd_in),
        .pgd_out(pgd_out), .pgd_oe(pgd_oe), .cfg_q(cfg_q), .cfg_valid_q(cfg_valid_q), .write_busy_q(write_busy_q)
    );
    cwsp_prog_model prog_u (.prog_clk(prog_clk), .pgd_in(pgd_in), .pgd_out(pgd_out), .pgd_oe(pgd_oe));

    always #20 clock = ~clock;

    always @(posedge clock)
    begin
        if (write_busy_q === 1'b1)
            busy_cycles++;
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            $display("[FAIL] t=%0t timeout cycles=%h limit=%h", $time, cyc, 20000);
            wrap_up();
        end
    end

    task automatic chk_cfg(input cwsp_pkg::cfg_s got, input cwsp_pkg::cfg_s exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reboot(input logic erase);
        @(posedge clock);
        resetn <= 1'b0;
        por_n <= ~erase;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        por_n <= 1'b1;
        repeat (8) @(posedge clock);
        chk_word({15'h0000, cfg_valid_q}, 16'h0001);
    endtask

    task automatic write_word(input logic [15:0] addr, input logic [15:0] val);
        int k;
        int b0;
        b0 = busy_cycles;
        prog_u.cfg_write(addr, val);
        k = 0;
        do
        begin
            prog_u.poll(rd);
            k++;
        end
        while (rd[15] !== 1'b0 && k < 20);
        chk_word(rd, 16'h4003);
        chk_word(16'(busy_cycles - b0), 16'(WR_CYC));
    endtask

    task automatic wrap_up();
        $display("checked %0d, failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        resetn = 1'b0;
        por_n = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        reboot(1'b1);
        chk_cfg(cfg_q, 64'hFFFF_FFFF_FFFF_7FFF);
        $display("test reload done");
        write_word(16'hFFF6, 16'h0000);
        reboot(1'b0);
        busy_base = busy_cycles;
        prog_u.exec(24'hA8E761);
        prog_u.exec(24'h000000);
        chk_word(16'(busy_cycles - busy_base), 16'h0000);
        prog_u.poll(rd);
        chk_word(rd, 16'h0000);
        $display("test refused start done");
        write_word(16'hFFF8, 16'h12F0);
        write_word(16'hFFFE, 16'h7FF0);
        chk_cfg(cfg_q, 64'hFFFF_FFFF_FFFF_7FFF);
        reboot(1'b0);
        chk_cfg(cfg_q, 64'h12F0_FFFF_FFFF_7FF0);
        $display("test config write done");
        write_word(16'hFFF8, 16'h0F0F);
        reboot(1'b0);
        chk_cfg(cfg_q, 64'h0200_FFFF_FFFF_7FF0);
        reboot(1'b1);
        chk_cfg(cfg_q, 64'hFFFF_FFFF_FFFF_7FFF);
        $display("test erase done");
        wrap_up();
    end
endmodule
`default_nettype wire

//--- test/cwsp_monitor.sv
// cwsp_monitor: port assertions for cwsp_top
// assumes: bound into cwsp_top; prog_clk stops between frames
`timescale 1ns/10ps
`default_nettype none
module cwsp_monitor
#(
    parameter int unsigned WRITE_CYCLES = 4
)
(
    // clocks and reset
    input wire logic           clock,
    input wire logic           resetn,
    input wire logic           prog_clk,
    // observed outputs
    input wire logic           pgd_oe,
    input wire cwsp_pkg::cfg_s cfg_q,
    input wire logic           cfg_valid_q,
    input wire logic           write_busy_q
);
    logic [15:0] busy_cnt_q;
    logic [15:0] busy_cnt_d;

    // length of the current write cycle
    assign busy_cnt_d = write_busy_q ? busy_cnt_q + 16'h0001 : 16'h0000;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            busy_cnt_q <= 16'h0000;
        else
            busy_cnt_q <= busy_cnt_d;
    end

    property p_reset_vals;
        @(posedge clock) disable iff (!resetn)
        $rose(resetn) |-> cfg_q == 64'hFFFF_FFFF_FFFF_7FFF && !cfg_valid_q && !write_busy_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad config values at reset");
    property p_valid_time;
        @(posedge clock) disable iff (!resetn)
        $rose(resetn) |-> ##[1:6] cfg_valid_q;
    endproperty
    a_valid_time: assert property (p_valid_time) else $error("reload too slow");
    property p_valid_stays;
        @(posedge clock) disable iff (!resetn)
        cfg_valid_q |=> cfg_valid_q;
    endproperty
    a_valid_stays: assert property (p_valid_stays) else $error("valid dropped without reset");
    property p_cfg_stable;
        @(posedge clock) disable iff (!resetn)
        cfg_valid_q |=> $stable(cfg_q);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("live config changed without reset");
    property p_busy_valid;
        @(posedge clock) disable iff (!resetn)
        write_busy_q |-> cfg_valid_q;
    endproperty
    a_busy_valid: assert property (p_busy_valid) else $error("write during reload");
    property p_busy_min;
        @(posedge clock) disable iff (!resetn)
        $fell(write_busy_q) |-> busy_cnt_q + 16'h0001 >= WRITE_CYCLES;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
    property p_busy_max;
        @(posedge clock) disable iff (!resetn)
        write_busy_q |-> busy_cnt_q < WRITE_CYCLES + 2;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
    property p_oe_len;
        @(posedge prog_clk) disable iff (!resetn)
        $rose(pgd_oe) |-> pgd_oe[*8] ##1 pgd_oe[*8] ##1 !pgd_oe;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("shift-out window not 16 bits");
endmodule

bind cwsp_top cwsp_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon_u
(
    .clock(clock), .resetn(resetn), .prog_clk(prog_clk), .pgd_oe(pgd_oe),
    .cfg_q(cfg_q), .cfg_valid_q(cfg_valid_q), .write_busy_q(write_busy_q)
);
`default_nettype wire

//--- test/cwsp_prog_model.sv
// cwsp_prog_model: external programmer on the serial programming pins
// assumes: link clock 64 ns, idle low between frames
`timescale 1ns/10ps
`default_nettype none
module cwsp_prog_model
(
    // programming pins
    output var  logic prog_clk,
    output wire logic pgd_in,
    input  wire logic pgd_out,
    input  wire logic pgd_oe
);
    logic drv;

    initial
    begin
        prog_clk = 1'b0;
        drv = 1'b0;
    end
    // pin level: device wins while it drives
    assign pgd_in = pgd_oe ? pgd_out : drv;

    task automatic frame(input logic [3:0] cmd, input logic [23:0] data, output logic [15:0] rd);
        logic [27:0] pat;
        pat = {data, cmd};
        rd = 16'h0000;
        #13;
        for (int i = 0; i < 28; i++)
        begin
            drv = pat[i];
            #32;
            if (pgd_oe === 1'b1)
                rd = {pgd_out, rd[15:1]};
            prog_clk = 1'b1;
            #32;
            prog_clk = 1'b0;
        end
        // released line must not keep its last value
        drv = ~drv;
    endtask

    task automatic exec(input logic [23:0] ins);
        logic [15:0] dummy;
        frame(4'h0, ins, dummy);
    endtask

    task automatic cfg_write(input logic [15:0] addr, input logic [15:0] val);
        exec(24'h000000); exec(24'h040200); exec(24'h000000);
        exec({4'h2, addr, 4'h7});
        exec(24'h24003A); exec(24'h883B0A);
        exec(24'h200000); exec(24'h880190);
        exec({4'h2, val, 4'h6});
        exec(24'h000000); exec(24'hBB1B86); exec(24'h000000); exec(24'h000000);
        exec(24'hA8E761); exec(24'h000000); exec(24'h000000);
    endtask

    task automatic poll(output logic [15:0] rd);
        exec(24'h040200); exec(24'h000000); exec(24'h803B02); exec(24'h883C22);
        exec(24'h000000);
        frame(4'h1, 24'h000000, rd);
        exec(24'h000000);
    endtask
endmodule
`default_nettype wire
